// ==== pkg/dbgm_regs.vh ====
// Constants for the debug memory write and block read command unit.
// Included by bare name from core files; definitions only.
`ifndef DBGM_REGS_VH
`define DBGM_REGS_VH

// Command word fields: group nibble, opcode nibble, size nibble, low nibble
`define DBGM_GRP_MEM      4'h1
`define DBGM_OP_WRITE     4'h8
`define DBGM_OP_READ      4'h9
`define DBGM_OP_DUMP      4'hD
`define DBGM_CMD_NOP      16'h0000

// Size nibble codes
`define DBGM_SZ_BYTE      4'h0
`define DBGM_SZ_WORD      4'h4
`define DBGM_SZ_LONG      4'h8
`define DBGM_LOW_NIB      4'h0

// Internal size codes, also driven on the memory bus
`define DBGM_SIZE_BYTE    2'h0
`define DBGM_SIZE_WORD    2'h1
`define DBGM_SIZE_LONG    2'h2

// Result words
`define DBGM_RSP_DONE     16'hFFFF
`define DBGM_RSP_ILLEGAL  16'h0001
`define DBGM_BYTE_PAD     8'h00

`endif

// ==== core/dbgm_bus.v ====
// Memory access unit of the debug command block: one access per start pulse.
// Assumes a simple synchronous memory port that answers each request with an ack.
`include "dbgm_regs.vh"

module dbgm_bus (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Request from the command sequencer
  input  wire        start_in,
  input  wire        we_in,
  input  wire [31:0] addr_in,
  input  wire [1:0]  size_in,
  input  wire [1:0]  tt_in,
  input  wire [2:0]  tm_in,
  input  wire [31:0] wdata_in,
  output reg         done_out,
  output reg  [31:0] rdata_out,
  // Memory port
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [31:0] mem_addr_out,
  output reg  [1:0]  mem_size_out,
  output reg  [1:0]  mem_tt_out,
  output reg  [2:0]  mem_tm_out,
  output reg  [31:0] mem_wdata_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in
);

  // Request held until ack; all port outputs registered
  always @(posedge clk_in) begin
    if (rst_in) begin
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 32'h00000000;
      mem_size_out  <= `DBGM_SIZE_BYTE;
      mem_tt_out    <= 2'h0;
      mem_tm_out    <= 3'h0;
      mem_wdata_out <= 32'h00000000;
      done_out      <= 1'b0;
      rdata_out     <= 32'h00000000;
    end else begin
      done_out <= 1'b0;
      if (mem_req_out) begin
        if (mem_ack_in) begin
          mem_req_out <= 1'b0;
          done_out    <= 1'b1;
          rdata_out   <= mem_rdata_in;
        end
      end else if (start_in) begin
        mem_req_out   <= 1'b1;
        mem_we_out    <= we_in;
        mem_addr_out  <= addr_in;
        mem_size_out  <= size_in;
        mem_tt_out    <= tt_in;      // Address space from attribute fields
        mem_tm_out    <= tm_in;
        mem_wdata_out <= wdata_in;
      end
    end
  end

endmodule

// ==== core/dbgm_top.v ====
// Debug memory command unit: memory write, memory read and sequential block read.
// Assumes 16-bit command words arrive already deframed from the serial debug
// shifter, and result words are taken by that shifter in the cycle they appear.
//
// Operation
// - A write command stores its operand at the given address in the space set by the attribute fields.
// - Word accesses are forced to even addresses and longword accesses to four-byte boundaries.
// - A write is 0x1/0x8/size/0x0 then address high, address low, then byte, word or two long halves.
// - A block read with no earlier memory read is answered with an illegal-command response.
// - After a read or block read the address plus operand size is kept as the next block-read pointer.
// - A block read is accepted only right after a no-op, a read or a block read, with no address check.
// - A no-op between block reads leaves the pointer untouched.
// - Each block read decodes its own size, so the step may change between commands.
// - A block read is 0x1/0xD/size/0x0 and returns a byte low, a word whole, or a long high then low.
`include "dbgm_regs.vh"

module dbgm_top (
  // Clock and reset
  input  wire        SYS_CLK_IN,
  input  wire        RST_IN,
  // Command words from the debug shifter
  input  wire [15:0] CMD_WORD_IN,
  input  wire        CMD_VALID_IN,
  output reg         CMD_READY_OUT,
  // Result words to the debug shifter
  output reg  [15:0] RSP_WORD_OUT,
  output reg         RSP_VALID_OUT,
  output reg         RSP_ILLEGAL_OUT,
  // Other debug commands break the block-read chain
  input  wire        OTHER_CMD_IN,
  // Fields of the debug_address_attribute_reg
  input  wire [1:0]  TRANSFER_TYPE_FIELD_IN,
  input  wire [2:0]  TRANSFER_MODIFIER_FIELD_IN,
  // Memory port
  output wire        MEM_REQ_OUT,
  output wire        MEM_WE_OUT,
  output wire [31:0] MEM_ADDR_OUT,
  output wire [1:0]  MEM_SIZE_OUT,
  output wire [1:0]  MEM_TT_OUT,
  output wire [2:0]  MEM_TM_OUT,
  output wire [31:0] MEM_WDATA_OUT,
  input  wire        MEM_ACK_IN,
  input  wire [31:0] MEM_RDATA_IN
);

  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_AHI  = 3'h1;
  localparam ST_ALO  = 3'h2;
  localparam ST_DHI  = 3'h3;
  localparam ST_DLO  = 3'h4;
  localparam ST_BUS  = 3'h5;
  localparam ST_RLO  = 3'h6;

  // Clear low address bits to the operand's natural boundary
  function [31:0] align_addr;
    input [31:0] a;
    input [1:0]  sz;
    begin
      case (sz)
        `DBGM_SIZE_WORD: align_addr = {a[31:1], 1'b0};
        `DBGM_SIZE_LONG: align_addr = {a[31:2], 2'b00};
        default:         align_addr = a;
      endcase
    end
  endfunction

  // Size nibble to size code; bit 2 flags an unknown nibble
  function [2:0] dec_size;
    input [3:0] nib;
    begin
      case (nib)
        `DBGM_SZ_BYTE: dec_size = {1'b0, `DBGM_SIZE_BYTE};
        `DBGM_SZ_WORD: dec_size = {1'b0, `DBGM_SIZE_WORD};
        `DBGM_SZ_LONG: dec_size = {1'b0, `DBGM_SIZE_LONG};
        default:       dec_size = 3'h4;
      endcase
    end
  endfunction

  // Bytes covered by one operand
  function [31:0] size_bytes;
    input [1:0] sz;
    begin
      case (sz)
        `DBGM_SIZE_WORD: size_bytes = 32'h00000002;
        `DBGM_SIZE_LONG: size_bytes = 32'h00000004;
        default:         size_bytes = 32'h00000001;
      endcase
    end
  endfunction

  reg  [2:0]  state_r;
  reg         is_write_r;
  reg  [1:0]  size_r;
  reg  [31:0] addr_r;
  reg  [31:0] wdata_r;
  reg  [31:0] ptr_r;
  reg         chain_ok_r;
  reg  [15:0] rlo_r;
  reg         bus_start_r;
  wire        bus_done;
  wire [31:0] bus_rdata;

  // Command word decode
  wire [2:0]  cmd_sz   = dec_size(CMD_WORD_IN[7:4]);
  wire        cmd_mem  = (CMD_WORD_IN[15:12] == `DBGM_GRP_MEM) &&
                         (CMD_WORD_IN[3:0] == `DBGM_LOW_NIB);
  wire        cmd_wr   = cmd_mem && (CMD_WORD_IN[11:8] == `DBGM_OP_WRITE);
  wire        cmd_rd   = cmd_mem && (CMD_WORD_IN[11:8] == `DBGM_OP_READ);
  wire        cmd_dump = cmd_mem && (CMD_WORD_IN[11:8] == `DBGM_OP_DUMP);
  wire        cmd_nop  = (CMD_WORD_IN == `DBGM_CMD_NOP);
  wire        take     = CMD_VALID_IN && CMD_READY_OUT;

  // Accesses run in a separate unit so the port timing stays in one place
  dbgm_bus u_bus (
    .clk_in        (SYS_CLK_IN),
    .rst_in        (RST_IN),
    .start_in      (bus_start_r),
    .we_in         (is_write_r),
    .addr_in       (addr_r),
    .size_in       (size_r),
    .tt_in         (TRANSFER_TYPE_FIELD_IN),
    .tm_in         (TRANSFER_MODIFIER_FIELD_IN),
    .wdata_in      (wdata_r),
    .done_out      (bus_done),
    .rdata_out     (bus_rdata),
    .mem_req_out   (MEM_REQ_OUT),
    .mem_we_out    (MEM_WE_OUT),
    .mem_addr_out  (MEM_ADDR_OUT),
    .mem_size_out  (MEM_SIZE_OUT),
    .mem_tt_out    (MEM_TT_OUT),
    .mem_tm_out    (MEM_TM_OUT),
    .mem_wdata_out (MEM_WDATA_OUT),
    .mem_ack_in    (MEM_ACK_IN),
    .mem_rdata_in  (MEM_RDATA_IN)
  );

  // Command sequencer; ready is dropped while an access or a long result runs
  always @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_r         <= ST_IDLE;
      is_write_r      <= 1'b0;
      size_r          <= `DBGM_SIZE_BYTE;
      addr_r          <= 32'h00000000;
      wdata_r         <= 32'h00000000;
      ptr_r           <= 32'h00000000;
      chain_ok_r      <= 1'b0;
      rlo_r           <= 16'h0000;
      bus_start_r     <= 1'b0;
      CMD_READY_OUT   <= 1'b1;
      RSP_WORD_OUT    <= 16'h0000;
      RSP_VALID_OUT   <= 1'b0;
      RSP_ILLEGAL_OUT <= 1'b0;
    end else begin
      bus_start_r     <= 1'b0;
      RSP_VALID_OUT   <= 1'b0;
      RSP_ILLEGAL_OUT <= 1'b0;
      // Foreign commands seen elsewhere break the chain
      if (OTHER_CMD_IN) begin
        chain_ok_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            if (cmd_nop) begin
              // Pointer kept for padding; a foreign command still breaks the chain
              ptr_r <= ptr_r;
            end else if ((cmd_wr || cmd_rd) && !cmd_sz[2]) begin
              is_write_r <= cmd_wr;
              size_r     <= cmd_sz[1:0];
              chain_ok_r <= 1'b0;
              state_r    <= ST_AHI;
            end else if (cmd_dump && !cmd_sz[2] && chain_ok_r) begin
              // No validity check on the pointer, size taken fresh each time
              is_write_r    <= 1'b0;
              size_r        <= cmd_sz[1:0];
              addr_r        <= align_addr(ptr_r, cmd_sz[1:0]);
              bus_start_r   <= 1'b1;
              CMD_READY_OUT <= 1'b0;
              state_r       <= ST_BUS;
            end else begin
              // Block read out of sequence or malformed word
              chain_ok_r      <= 1'b0;
              RSP_WORD_OUT    <= `DBGM_RSP_ILLEGAL;
              RSP_VALID_OUT   <= 1'b1;
              RSP_ILLEGAL_OUT <= 1'b1;
            end
          end
        end
        ST_AHI: begin
          if (take) begin
            addr_r[31:16] <= CMD_WORD_IN;
            state_r       <= ST_ALO;
          end
        end
        ST_ALO: begin
          if (take) begin
            addr_r <= align_addr({addr_r[31:16], CMD_WORD_IN}, size_r);
            if (!is_write_r) begin
              bus_start_r   <= 1'b1;
              CMD_READY_OUT <= 1'b0;
              state_r       <= ST_BUS;
            end else if (size_r == `DBGM_SIZE_LONG) begin
              state_r <= ST_DHI;
            end else begin
              state_r <= ST_DLO;
            end
          end
        end
        ST_DHI: begin
          if (take) begin
            wdata_r[31:16] <= CMD_WORD_IN;
            state_r        <= ST_DLO;
          end
        end
        ST_DLO: begin
          if (take) begin
            // Byte data sits in the low eight bits of the word
            if (size_r == `DBGM_SIZE_LONG) begin
              wdata_r[15:0] <= CMD_WORD_IN;
            end else begin
              wdata_r <= {16'h0000, CMD_WORD_IN};
            end
            bus_start_r   <= 1'b1;
            CMD_READY_OUT <= 1'b0;
            state_r       <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (bus_done) begin
            RSP_VALID_OUT <= 1'b1;
            if (is_write_r) begin
              RSP_WORD_OUT  <= `DBGM_RSP_DONE;
              CMD_READY_OUT <= 1'b1;
              state_r       <= ST_IDLE;
            end else begin
              // Next block read starts one operand further on
              ptr_r      <= addr_r + size_bytes(size_r);
              chain_ok_r <= !OTHER_CMD_IN;
              rlo_r      <= bus_rdata[15:0];
              case (size_r)
                `DBGM_SIZE_LONG: begin
                  RSP_WORD_OUT <= bus_rdata[31:16];
                  state_r      <= ST_RLO;
                end
                `DBGM_SIZE_WORD: begin
                  RSP_WORD_OUT  <= bus_rdata[15:0];
                  CMD_READY_OUT <= 1'b1;
                  state_r       <= ST_IDLE;
                end
                default: begin
                  RSP_WORD_OUT  <= {`DBGM_BYTE_PAD, bus_rdata[7:0]};
                  CMD_READY_OUT <= 1'b1;
                  state_r       <= ST_IDLE;
                end
              endcase
            end
          end
        end
        ST_RLO: begin
          RSP_WORD_OUT  <= rlo_r;
          RSP_VALID_OUT <= 1'b1;
          CMD_READY_OUT <= 1'b1;
          state_r       <= ST_IDLE;
        end
        default: begin
          CMD_READY_OUT <= 1'b1;
          state_r       <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== verification/dbgm_chk_monitor.sv ====
// Port checker for the debug memory command unit.
// Assumes the memory side raises its ack only while a request is up.
module dbgm_chk (
  input logic        SYS_CLK_IN, RST_IN, CMD_VALID_IN, CMD_READY_OUT, OTHER_CMD_IN,
  input logic [15:0] CMD_WORD_IN, RSP_WORD_OUT,
  input logic        RSP_VALID_OUT, RSP_ILLEGAL_OUT, MEM_REQ_OUT, MEM_WE_OUT, MEM_ACK_IN,
  input logic [31:0] MEM_ADDR_OUT, MEM_RDATA_IN,
  input logic [1:0]  MEM_SIZE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_r, rd2_r, rd3_r;
  logic        brk_r;
  wire         fin = MEM_REQ_OUT && MEM_ACK_IN;
  wire         rd_fin = fin && !MEM_WE_OUT;
  // Read data history; chain broken until the next word after reset or a foreign command
  always @(posedge SYS_CLK_IN) begin
    rd_r <= MEM_RDATA_IN;
    rd2_r <= rd_r;
    rd3_r <= rd2_r;
    if (RST_IN || OTHER_CMD_IN)
      brk_r <= 1'b1;
    else if (CMD_VALID_IN && CMD_READY_OUT)
      brk_r <= 1'b0;
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  req_hold_a: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=>
    MEM_REQ_OUT && $stable(MEM_ADDR_OUT)) else $error("request moved before ack");
  word_align_a: assert property (MEM_REQ_OUT && MEM_SIZE_OUT == 2'h1 |-> !MEM_ADDR_OUT[0])
    else $error("odd word address");
  long_align_a: assert property (MEM_REQ_OUT && MEM_SIZE_OUT == 2'h2 |->
    MEM_ADDR_OUT[1:0] == 2'h0) else $error("unaligned long address");
  // Result word shows two edges after the ack: done pulse, then the registered word
  write_ans_a: assert property (fin && MEM_WE_OUT |-> ##2
    (RSP_VALID_OUT && !RSP_ILLEGAL_OUT && RSP_WORD_OUT == 16'hFFFF)) else $error("write unanswered");
  byte_res_a: assert property (rd_fin && MEM_SIZE_OUT == 2'h0 |-> ##2
    (RSP_VALID_OUT && RSP_WORD_OUT == {8'h00, rd2_r[7:0]})) else $error("byte result wrong");
  long_res_a: assert property (rd_fin && MEM_SIZE_OUT == 2'h2 |-> ##2
    (RSP_VALID_OUT && RSP_WORD_OUT == rd2_r[31:16]) ##1 (RSP_VALID_OUT && RSP_WORD_OUT == rd3_r[15:0])
    ##1 !RSP_VALID_OUT) else $error("long halves wrong");
  ill_word_a: assert property (RSP_ILLEGAL_OUT |->
    RSP_VALID_OUT && RSP_WORD_OUT == 16'h0001) else $error("illegal word wrong");
  cold_dump_a: assert property (CMD_VALID_IN && CMD_READY_OUT && brk_r &&
    CMD_WORD_IN[15:8] == 8'h1D && CMD_WORD_IN[3:0] == 4'h0 |=> RSP_ILLEGAL_OUT && !MEM_REQ_OUT)
    else $error("unarmed block read ran");
  cover property (rd_fin && MEM_SIZE_OUT == 2'h2);
  cover property (fin && MEM_WE_OUT);
  cover property (RSP_ILLEGAL_OUT);
endmodule

// ==== verification/dbgm_mem_model.sv ====
// Memory responder for the unit's memory port, prompt or slow.
// Assumes requests are held until acked; data between acks is inverted.
module dbgm_mem_model (
  input  logic        clk_in, rst_in, req_in, slow_in,
  input  logic [31:0] addr_in,
  output logic        ack_out,
  output logic [31:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  // Halves differ so a swapped result shows
  function automatic [31:0] pat(input [31:0] a);
    pat = {a[15:0] ^ 16'hC3A5, a[15:0] ^ 16'h5A0F};
  endfunction
  // Ack after zero or three idle cycles, one cycle wide
  always @(posedge clk_in) begin
    if (rst_in || !req_in || ack_out) begin
      wait_r <= slow_in ? 2'h3 : 2'h0;
      ack_out <= 1'b0;
    end else if (wait_r != 2'h0)
      wait_r <= wait_r - 2'h1;
    else
      ack_out <= 1'b1;
  end
  assign rdata_out = ack_out ? pat(addr_in) : ~pat(addr_in);
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the debug memory command unit.
// Assumes the memory model and the port checker are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, other = 1'b0, slow = 1'b0, armed = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic [1:0]  tt = 2'h0;
  logic [2:0]  tm = 3'h0;
  logic [31:0] ptr = 32'h0, r;
  wire         ready, rsp_v, rsp_ill, req, we, ack;
  wire [15:0]  rsp_w;
  wire [31:0]  maddr, mwdata, mrdata;
  wire [1:0]   msz, mtt;
  wire [2:0]   mtm;
  integer      seed = 23819, n_mismatch = 0, check_count = 0, i;
  logic [16:0] exp_rsp[$];
  logic [71:0] exp_mem[$];

  // System clock
  always #12.5 clk = ~clk;
  dbgm_top dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .CMD_WORD_IN(cmd_word), .CMD_VALID_IN(cmd_valid),
    .CMD_READY_OUT(ready), .RSP_WORD_OUT(rsp_w), .RSP_VALID_OUT(rsp_v), .RSP_ILLEGAL_OUT(rsp_ill),
    .OTHER_CMD_IN(other), .TRANSFER_TYPE_FIELD_IN(tt), .TRANSFER_MODIFIER_FIELD_IN(tm),
    .MEM_REQ_OUT(req), .MEM_WE_OUT(we), .MEM_ADDR_OUT(maddr), .MEM_SIZE_OUT(msz), .MEM_TT_OUT(mtt),
    .MEM_TM_OUT(mtm), .MEM_WDATA_OUT(mwdata), .MEM_ACK_IN(ack), .MEM_RDATA_IN(mrdata));
  dbgm_mem_model mem_u (.clk_in(clk), .rst_in(rst), .req_in(req), .slow_in(slow), .addr_in(maddr),
    .ack_out(ack), .rdata_out(mrdata));

  function automatic [31:0] dmask(input [1:0] sz);
    dmask = (sz == 2'h2) ? 32'hFFFFFFFF : (32'h1 << (5'h8 << sz)) - 32'h1;
  endfunction
  task check(input string name, input [71:0] seen, input [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task quit;
    n_mismatch++;
    end_of_test;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // Word held until an edge sees ready high
  task send(input [15:0] w);
    integer k;
    cmd_word = w;
    cmd_valid = 1'b1;
    for (k = 0; ready !== 1'b1 && k < 300; k++)
      tick;
    if (k >= 300)
      quit;
    tick;
  endtask
  // One command with operands; expectations noted first, then drained
  task mem_cmd(input [3:0] op, input [1:0] sz, input [31:0] a, input [31:0] d);
    logic [31:0] al, f;
    integer      k;
    r = $random(seed);
    tt = r[1:0];
    tm = r[4:2];
    al = ((op == 4'hD) ? ptr : a) & ~((32'h1 << sz) - 32'h1);
    f = mem_u.pat(al) & dmask(sz);
    if (op == 4'hD && !armed)
      exp_rsp.push_back({1'b1, 16'h0001});
    else begin
      exp_mem.push_back({op == 4'h8, al, sz, tt, tm, (op == 4'h8) ? d & dmask(sz) : 32'h0});
      if (op == 4'h8)
        exp_rsp.push_back({1'b0, 16'hFFFF});
      else if (sz == 2'h2)
        exp_rsp.push_back({1'b0, f[31:16]});
      if (op != 4'h8)
        exp_rsp.push_back({1'b0, f[15:0]});
      ptr = al + (32'h1 << sz);
      armed = (op != 4'h8);
    end
    send({4'h1, op, sz, 6'h00});
    if (op != 4'hD) begin
      send(a[31:16]);
      send(a[15:0]);
    end
    if (op == 4'h8 && sz == 2'h2)
      send(d[31:16]);
    if (op == 4'h8)
      send(d[15:0]); // Byte write sends a random upper byte
    cmd_valid = 1'b0;
    tick;
    for (k = 0; (exp_rsp.size() > 0 || req === 1'b1) && k < 300; k++)
      tick;
    if (k >= 300)
      quit;
  endtask

  // Oldest note against each result word and each finished access
  always @(posedge clk)
    if (!rst) begin
      if (rsp_v === 1'b1)
        check("result", {rsp_ill, rsp_w}, exp_rsp.size() ? exp_rsp.pop_front() : 72'h100000);
      if (req === 1'b1 && ack === 1'b1)
        check("access", {we, maddr, msz, mtt, mtm, we ? mwdata & dmask(msz) : 32'h0},
              exp_mem.size() ? exp_mem.pop_front() : ~72'h0);
    end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    tick;
    mem_cmd(4'hD, 2'h2, 32'h0, 32'h0);
    for (i = 0; i < 3; i++)
      mem_cmd(4'h8, i[1:0], $random(seed), $random(seed));
    // Write with an unknown size nibble is refused
    exp_rsp.push_back({1'b1, 16'h0001});
    send(16'h18C0);
    cmd_valid = 1'b0;
    repeat (2) tick;
    mem_cmd(4'hD, 2'h1, 32'h0, 32'h0);
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      slow = r[5];
      mem_cmd((i % 7 == 0) ? 4'h9 : 4'hD, (r[1:0] == 2'h3) ? 2'h1 : r[1:0], $random(seed),
              32'h0);
      if (r[6])
        send(16'h0000);
    end
    cmd_valid = 1'b0;
    other = 1'b1;
    armed = 1'b0;
    tick;
    other = 1'b0;
    mem_cmd(4'hD, 2'h0, 32'h0, 32'h0);
    end_of_test;
  end
endmodule

bind dbgm_top dbgm_chk chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_READY_OUT(CMD_READY_OUT), .OTHER_CMD_IN(OTHER_CMD_IN), .CMD_WORD_IN(CMD_WORD_IN),
  .RSP_WORD_OUT(RSP_WORD_OUT), .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_ILLEGAL_OUT(RSP_ILLEGAL_OUT),
  .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_WE_OUT(MEM_WE_OUT), .MEM_ACK_IN(MEM_ACK_IN),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RDATA_IN(MEM_RDATA_IN), .MEM_SIZE_OUT(MEM_SIZE_OUT));
